// File: inc/ext_ctl_map.svh
`ifndef EXT_CTL_MAP_SVH
`define EXT_CTL_MAP_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_KHZ      32'h0001_86A0
`define BOUNCE_MS         32'h0000_001E
`define STABLE_CYC_DEF    (`BOUNCE_MS * `CLK_FREQ_KHZ + 32'h0000_0001)

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_EVT_STAT      8'h08
`define REG_EVT_MASK      8'h0C
`define REG_HI_LIMIT      8'h10
`define REG_LO_LIMIT      8'h14
`define REG_POLL_BYTE     8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_PULSE_MODE   0
`define CTRL_TALK_ONLY    1
`define ST_RUN            0
`define ST_PASS           1
`define ST_ALARM          2
`define ST_REMOTE         3
`define ST_TALKER         4
`define ST_LISTENER       5
`define ST_POLL_MODE      6
`define ST_SRQ            7
`define EV_END_MEAS       0
`define EV_END_RECALL     1
`define EV_EXT_SRQ        2
`define EV_SYNTAX         3
`define EV_ALARM          4
`define EV_MEM_FULL       5
`define POLL_RQS          6

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define EV_W              6
`define CTRL_RST          2'h0
`define EV_MASK_RST       6'h00
`define HI_LIMIT_RST      32'h7FFF_FFFF
`define LO_LIMIT_RST      32'h8000_0000

`endif

// File: inc/ext_ctl_pkg.sv
`default_nettype none
package ext_ctl_pkg;

    // Pass sequencer states
    typedef enum logic [0:0] {
        SCAN_IDLE,
        SCAN_PASS
    } scan_state_e;

    // Bus messages decoded by the handshake front end
    typedef enum logic [3:0] {
        BC_NONE,
        BC_MLA,
        BC_MTA,
        BC_OTA,
        BC_UNL,
        BC_UNT,
        BC_SDC,
        BC_DCL,
        BC_GET,
        BC_SPE,
        BC_SPD,
        BC_GTL,
        BC_PPOLL,
        BC_IFC,
        BC_REN_ON,
        BC_REN_OFF
    } bus_cmd_e;

    typedef struct packed {
        logic     valid;
        bus_cmd_e code;
    } bus_cmd_s;

    typedef struct packed {
        logic remote;
        logic talker;
        logic listener;
        logic poll_mode;
    } bus_state_s;

endpackage
`default_nettype wire

// File: rtl/contact_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_ctl_map.svh"
module contact_filter
    import ext_ctl_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = `STABLE_CYC_DEF
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic raw_i,
    output logic      level_o,
    output logic      rise_o
);

    logic [2:0]  sync;
    logic [31:0] stable_cnt;
    logic        agree;
    logic        differs;
    logic        accept;

    // ------------------------------------------------------------------------
    // Decisions
    // ------------------------------------------------------------------------
    // Only the second and third stages are compared; the first stage may be
    // metastable and feeds the second stage alone.
    assign agree   = (sync[1] == sync[2]);
    assign differs = agree && (sync[2] != level_o);
    assign accept  = differs && (stable_cnt == STABLE_CYCLES);

    // Three-stage synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync <= 3'h0;
        end else begin
            sync <= {sync[1:0], raw_i};
        end
    end

    // New level must hold past the bounce window; any glitch restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i || !differs || accept) begin
            stable_cnt <= 32'h0000_0000;
        end else begin
            stable_cnt <= stable_cnt + 32'h0000_0001;
        end
    end

    // Accepted level and its rising-edge pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            rise_o  <= accept && sync[2];
            if (accept) begin
                level_o <= sync[2];
            end
        end
    end

endmodule
`default_nettype wire

// File: rtl/external_control.sv
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ext_ctl_map.svh"
module external_control
    import ext_ctl_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = `STABLE_CYC_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // Contacts
    input  wire logic        run_contact_i,
    input  wire logic        single_contact_i,
    input  wire logic        srq_contact_i,
    // Measurement engine
    input  wire logic        interval_tick_i,
    input  wire logic        pass_done_i,
    input  wire logic        meas_valid_i,
    input  wire logic [31:0] meas_value_i,
    input  wire logic        recall_done_i,
    input  wire logic        syntax_err_i,
    input  wire logic        mem_full_i,
    output logic             pass_start_o,
    output logic             scan_busy_n_o,
    output logic             alarm_close_o,
    // Bus front end
    input  wire bus_cmd_s    bus_cmd_i,
    input  wire logic        poll_byte_sent_i,
    output bus_state_s       bus_state_o,
    output logic [7:0]       poll_byte_o,
    output logic             srq_o,
    output logic             srq_oe_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [1:0]        ctrl;
    logic [`EV_W-1:0]  evt_stat;
    logic [`EV_W-1:0]  evt_mask;
    logic [`EV_W-1:0]  srq_pend;
    logic [31:0]       hi_limit;
    logic [31:0]       lo_limit;
    logic              rqs;
    logic              run_toggle;
    logic              single_pend;
    logic              alarm;
    scan_state_e       state;
    scan_state_e       next_state;
    bus_state_s        bstate;
    bus_state_s        next_bstate;

    logic              run_level;
    logic              run_rise;
    logic              single_rise;
    logic              srq_rise;
    logic              run;
    logic              bus_trigger;
    logic              start_pass;
    logic              hit;
    logic [`EV_W-1:0]  events;
    logic              bus_clear;
    logic              poll_done;

    logic              wb_req;
    logic              wb_wr;
    logic              wb_rd;
    logic [31:0]       rd_mux;
    logic [31:0]       wmask;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Byte-lane merge, shared by the control, mask and limit registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [31:0] m);
        lane_merge = (old & ~m) | (nw & m);
    endfunction

    // Sticky update: a set in the same cycle as the clear wins
    function automatic logic [`EV_W-1:0] sticky(input logic [`EV_W-1:0] cur,
                                                input logic [`EV_W-1:0] set,
                                                input logic [`EV_W-1:0] clr);
        sticky = (cur & ~clr) | set;
    endfunction

    // ------------------------------------------------------------------------
    // Contact conditioning
    // ------------------------------------------------------------------------
    contact_filter #(
        .STABLE_CYCLES (STABLE_CYCLES)
    ) u_run_filter (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (run_contact_i),
        .level_o (run_level),
        .rise_o  (run_rise)
    );

    contact_filter #(
        .STABLE_CYCLES (STABLE_CYCLES)
    ) u_single_filter (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (single_contact_i),
        .level_o (),
        .rise_o  (single_rise)
    );

    contact_filter #(
        .STABLE_CYCLES (STABLE_CYCLES)
    ) u_srq_filter (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (srq_contact_i),
        .level_o (),
        .rise_o  (srq_rise)
    );

    // ------------------------------------------------------------------------
    // Scan control
    // ------------------------------------------------------------------------
    // Level mode follows the contact; pulse mode flips on each closure
    assign run = ctrl[`CTRL_PULSE_MODE] ? run_toggle : run_level;
    assign bus_trigger = bus_cmd_i.valid && (bus_cmd_i.code == BC_GET)
                         && bstate.listener;
    // A one-pass request arriving mid-pass is kept and served right after it
    assign start_pass = (state == SCAN_IDLE)
                        && (single_pend || (run && interval_tick_i));
    assign next_state = (state == SCAN_IDLE) ? (start_pass ? SCAN_PASS : SCAN_IDLE)
                        : (pass_done_i ? SCAN_IDLE : SCAN_PASS);

    // Toggle for pulse mode, cleared when leaving it so level mode is clean
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl[`CTRL_PULSE_MODE]) begin
            run_toggle <= 1'b0;
        end else if (run_rise) begin
            run_toggle <= !run_toggle;
        end
    end

    // One-pass request holder: contact pulse or bus trigger
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            single_pend <= 1'b0;
        end else if (single_rise || bus_trigger) begin
            single_pend <= 1'b1;
        end else if (start_pass) begin
            single_pend <= 1'b0;
        end
    end

    // Pass sequencer; busy output is its own flop, loaded from the next state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= SCAN_IDLE;
            pass_start_o  <= 1'b0;
            scan_busy_n_o <= 1'b1;
        end else begin
            state         <= next_state;
            pass_start_o  <= start_pass;
            scan_busy_n_o <= (next_state != SCAN_PASS);
        end
    end

    // ------------------------------------------------------------------------
    // Alarm contact
    // ------------------------------------------------------------------------
    // Judged per value in one cycle, far inside the response limit
    assign hit = ($signed(meas_value_i) > $signed(hi_limit))
                 || ($signed(meas_value_i) < $signed(lo_limit));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm <= 1'b0;
        end else if (meas_valid_i) begin
            alarm <= hit;
        end
    end
    assign alarm_close_o = alarm;

    // ------------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------------
    assign events[`EV_END_MEAS]   = (state == SCAN_PASS) && pass_done_i;
    assign events[`EV_END_RECALL] = recall_done_i;
    assign events[`EV_EXT_SRQ]    = srq_rise;
    assign events[`EV_SYNTAX]     = syntax_err_i;
    assign events[`EV_ALARM]      = meas_valid_i && hit && !alarm;
    assign events[`EV_MEM_FULL]   = mem_full_i;

    // ------------------------------------------------------------------------
    // Bus interface functions
    // ------------------------------------------------------------------------
    assign bus_clear = bus_cmd_i.valid && ((bus_cmd_i.code == BC_DCL)
                       || (bus_cmd_i.code == BC_IFC)
                       || ((bus_cmd_i.code == BC_SDC) && bstate.listener));
    assign poll_done = poll_byte_sent_i && bstate.talker && bstate.poll_mode;

    // Addressing; parallel-poll messages fall through untouched
    always_comb begin
        next_bstate = bstate;
        if (bus_cmd_i.valid) begin
            unique case (bus_cmd_i.code)
                BC_MLA: begin
                    next_bstate.listener = 1'b1;
                    next_bstate.talker   = 1'b0;
                    if (bstate.remote || bstate.listener) begin
                        next_bstate.remote = 1'b1;
                    end
                end
                BC_MTA: begin
                    next_bstate.talker   = 1'b1;
                    next_bstate.listener = 1'b0;
                end
                BC_OTA, BC_UNT: next_bstate.talker = 1'b0;
                BC_UNL: next_bstate.listener = 1'b0;
                BC_SPE: next_bstate.poll_mode = 1'b1;
                BC_SPD: next_bstate.poll_mode = 1'b0;
                BC_GTL: begin
                    if (bstate.listener) begin
                        next_bstate.remote = 1'b0;
                    end
                end
                BC_REN_ON: next_bstate.remote = bstate.listener;
                BC_REN_OFF: next_bstate.remote = 1'b0;
                BC_IFC: begin
                    next_bstate.talker    = 1'b0;
                    next_bstate.listener  = 1'b0;
                    next_bstate.poll_mode = 1'b0;
                end
                BC_DCL, BC_SDC: next_bstate.poll_mode = bstate.poll_mode && !bus_clear;
                BC_NONE, BC_GET, BC_PPOLL: next_bstate = bstate;
            endcase
        end
        // Talk-only: always talking, never listening, needs no controller
        if (ctrl[`CTRL_TALK_ONLY]) begin
            next_bstate.talker   = 1'b1;
            next_bstate.listener = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bstate <= '0;
        end else begin
            bstate <= next_bstate;
        end
    end
    assign bus_state_o = bstate;

    // Pending service causes; a poll clears what it reported, clear keeps only this cycle's events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srq_pend <= '0;
            rqs      <= 1'b0;
        end else if (bus_clear) begin
            srq_pend <= events;
            rqs      <= |events;
        end else begin
            srq_pend <= sticky(srq_pend, events, poll_done ? srq_pend : '0);
            rqs      <= (|events) || (rqs && !poll_done);
        end
    end

    // Status byte for serial poll; line pulled while request stands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            poll_byte_o <= 8'h00;
        end else begin
            poll_byte_o <= {1'b0, rqs, srq_pend};
        end
    end
    assign srq_o    = 1'b0;
    assign srq_oe_o = rqs;

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_req && wb_we_i;
    assign wb_rd  = wb_req && !wb_we_i;
    assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Read selection; unmapped offsets read as zero and are still acked
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_adr_i)
            `REG_CTRL:      rd_mux = {30'h0000_0000, ctrl};
            `REG_STATUS:    rd_mux = {24'h00_0000, rqs, bstate.poll_mode,
                                      bstate.listener, bstate.talker, bstate.remote,
                                      alarm, (state == SCAN_PASS), run};
            `REG_EVT_STAT:  rd_mux = {26'h000_0000, evt_stat};
            `REG_EVT_MASK:  rd_mux = {26'h000_0000, evt_mask};
            `REG_HI_LIMIT:  rd_mux = hi_limit;
            `REG_LO_LIMIT:  rd_mux = lo_limit;
            `REG_POLL_BYTE: rd_mux = {24'h00_0000, poll_byte_o};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_rd) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // Writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= `CTRL_RST;
            evt_mask <= `EV_MASK_RST;
            hi_limit <= `HI_LIMIT_RST;
            lo_limit <= `LO_LIMIT_RST;
        end else if (wb_wr) begin
            if (wb_adr_i == `REG_CTRL) begin
                ctrl <= 2'(lane_merge({30'h0000_0000, ctrl}, wb_dat_i, wmask));
            end
            if (wb_adr_i == `REG_EVT_MASK) begin
                evt_mask <= `EV_W'(lane_merge({26'h000_0000, evt_mask}, wb_dat_i,
                                              wmask));
            end
            if (wb_adr_i == `REG_HI_LIMIT) begin
                hi_limit <= lane_merge(hi_limit, wb_dat_i, wmask);
            end
            if (wb_adr_i == `REG_LO_LIMIT) begin
                lo_limit <= lane_merge(lo_limit, wb_dat_i, wmask);
            end
        end
    end

    // Event status: write one to clear, new events win over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_stat <= '0;
        end else begin
            evt_stat <= sticky(evt_stat, events,
                               (wb_wr && (wb_adr_i == `REG_EVT_STAT) && wb_sel_i[0])
                               ? wb_dat_i[`EV_W-1:0] : '0);
        end
    end

    // Level interrupt
    assign irq_o = |(evt_stat & evt_mask);

endmodule
`default_nettype wire

// File: verif/external_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module external_control_monitor
    import ext_ctl_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       pass_done_i,
    input wire logic       pass_start_o,
    input wire logic       scan_busy_n_o,
    input wire logic       meas_valid_i,
    input wire logic       alarm_close_o,
    input wire bus_cmd_s   bus_cmd_i,
    input wire bus_state_s bus_state_o
);
    // --------
    // Port relations
    // --------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Decoded bus messages
    wire is_mta = bus_cmd_i.valid && bus_cmd_i.code == BC_MTA;
    wire is_mla = bus_cmd_i.valid && bus_cmd_i.code == BC_MLA;
    wire is_pp  = bus_cmd_i.valid && bus_cmd_i.code == BC_PPOLL;

    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_start_busy: assert property (pass_start_o |-> !scan_busy_n_o)
        else $error("pass start without busy");
    a_busy_cause: assert property ($fell(scan_busy_n_o) |-> pass_start_o)
        else $error("busy without pass start");
    a_busy_release: assert property (!scan_busy_n_o && pass_done_i |=> scan_busy_n_o)
        else $error("busy held after pass done");
    a_start_single: assert property (pass_start_o |=> !pass_start_o)
        else $error("pass start repeated");
    a_alarm_hold: assert property (!meas_valid_i |=> $stable(alarm_close_o))
        else $error("alarm moved idle");
    a_talk_sel: assert property (is_mta |=> bus_state_o.talker && !bus_state_o.listener)
        else $error("talk address kept listener");
    a_listen_sel: assert property (is_mla |=> bus_state_o.listener != bus_state_o.talker)
        else $error("listen address kept talker");
    a_ppoll_quiet: assert property (is_pp && !wb_stb_i |=> $stable(bus_state_o))
        else $error("parallel poll changed state");

    // Main scenarios reached
    c_pass: cover property (pass_start_o);
    c_alarm: cover property ($rose(alarm_close_o));
    c_talker: cover property ($rose(bus_state_o.talker));
endmodule

bind external_control external_control_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .pass_done_i(pass_done_i), .pass_start_o(pass_start_o),
    .scan_busy_n_o(scan_busy_n_o), .meas_valid_i(meas_valid_i),
    .alarm_close_o(alarm_close_o), .bus_cmd_i(bus_cmd_i), .bus_state_o(bus_state_o));
`default_nettype wire

// File: verif/scan_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module scan_engine_model #(
    parameter int unsigned DELAY = 5
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pass_start_i,
    output logic      pass_done_o
);
    logic [7:0] left;

    // One done pulse per started pass
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left <= 8'h00;
            pass_done_o <= 1'b0;
        end else begin
            pass_done_o <= (left == 8'h01);
            if (pass_start_i) begin
                left <= 8'(DELAY);
            end else if (left != 8'h00) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/external_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_ctl_map.svh"
module external_control_test import ext_ctl_pkg::*;;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, mv = 1'b0, tick = 1'b0, ps = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, mval = 32'h0000_0000, rdat, wdo;
    logic [2:0]  cont = 3'h0, evp = 3'h0;
    bus_cmd_s    cmd = '0;
    logic        ack, irq, pst, busy_n, alarm, srq, srq_oe, done;
    bus_state_s  bst, s;
    logic [7:0]  pb;
    int          fail_count = 0, checked = 0;

    // Short window keeps contact tests brief
    external_control #(.STABLE_CYCLES(8)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
        .irq_o(irq), .run_contact_i(cont[0]), .single_contact_i(cont[1]),
        .srq_contact_i(cont[2]), .interval_tick_i(tick), .pass_done_i(done),
        .meas_valid_i(mv), .meas_value_i(mval), .recall_done_i(evp[0]),
        .syntax_err_i(evp[1]), .mem_full_i(evp[2]), .pass_start_o(pst),
        .scan_busy_n_o(busy_n), .alarm_close_o(alarm), .bus_cmd_i(cmd),
        .poll_byte_sent_i(ps), .bus_state_o(bst), .poll_byte_o(pb), .srq_o(srq),
        .srq_oe_o(srq_oe));
    scan_engine_model #(.DELAY(5)) u_eng (
        .clk_i(clk_i), .rst_i(rst_i), .pass_start_i(pst), .pass_done_o(done));

    // --------
    // Shared tasks
    // --------
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask

    task chb(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    task end_sim;
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Classic cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = wdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) chb(1'b0, 1'b1);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, '0);
        chk(rdat, e);
    endtask

    task tap(input logic [2:0] v);
        @(posedge clk_i);
        evp <= v;
        @(posedge clk_i);
        evp <= 3'h0;
        @(posedge clk_i);
    endtask

    task send(input bus_cmd_e c);
        @(posedge clk_i);
        cmd <= {1'b1, c};
        @(posedge clk_i);
        cmd <= '0;
        @(posedge clk_i);
    endtask

    // Contact closed len cycles, then open past the window
    task press(input int k, input int len);
        @(posedge clk_i);
        cont[k] <= 1'b1;
        repeat (len) @(posedge clk_i);
        cont[k] <= 1'b0;
        repeat (30) @(posedge clk_i);
    endtask

    task starts(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk_i);
            if (pst === 1'b1) c++;
        end
    endtask

    task tick_run(output int c);
        @(posedge clk_i);
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
        starts(20, c);
    endtask

    task meas(input logic [31:0] v, input logic e);
        @(posedge clk_i);
        mv <= 1'b1;
        mval <= v;
        @(posedge clk_i);
        mv <= 1'b0;
        @(posedge clk_i);
        chb(alarm, e);
    endtask

    // --------
    // Scenarios
    // --------
    task t_reset;
        chb(busy_n, 1'b1);
        rd(`REG_HI_LIMIT, 32'h7fff_ffff);
        rd(`REG_LO_LIMIT, 32'h8000_0000);
        wb(1'b1, 8'h1c, 32'hffff_ffff);
        rd(8'h1c, 32'h0000_0000);
    endtask

    task t_contacts;
        int c, n;
        fork press(1, 3); starts(40, c); join
        chk(c, 0);
        fork press(1, 30); starts(80, c); join
        chk(c, 1);
        chb(busy_n, 1'b1);
        cont[0] <= 1'b1;
        repeat (20) @(posedge clk_i);
        n = 0;
        repeat (3) begin
            tick_run(c);
            n += c;
        end
        chk(n, 3);
        cont[0] <= 1'b0;
        repeat (20) @(posedge clk_i);
        tick_run(c);
        chk(c, 0);
        wb(1'b1, `REG_CTRL, 32'h0000_0001);
        press(0, 30);
        tick_run(c);
        chk(c, 1);
        press(0, 30);
        tick_run(c);
        chk(c, 0);
    endtask

    task t_alarm;
        wb(1'b1, `REG_HI_LIMIT, 32'h0000_0064);
        wb(1'b1, `REG_LO_LIMIT, 32'hffff_ff9c);
        meas(32'h0000_0065, 1'b1);
        meas(32'h0000_0064, 1'b0);
        meas(32'hffff_ff9b, 1'b1);
        meas(32'hffff_ff9c, 1'b0);
    endtask

    task t_events;
        rd(`REG_EVT_STAT, 32'h0000_0011);
        wb(1'b1, `REG_EVT_STAT, 32'h0000_003f);
        send(BC_DCL);
        chb(srq_oe, 1'b0);
        tap(3'h7);
        chb(srq_oe, 1'b1);
        press(2, 30);
        rd(`REG_EVT_STAT, 32'h0000_002e);
        chb(irq, 1'b0);
        wb(1'b1, `REG_EVT_MASK, 32'h0000_0002);
        chb(irq, 1'b1);
        wb(1'b1, `REG_EVT_STAT, 32'h0000_0002);
        chb(irq, 1'b0);
        rd(`REG_EVT_STAT, 32'h0000_002c);
    endtask

    task t_bus;
        int c;
        s = bst;
        send(BC_PPOLL);
        chk(32'(bst), 32'(s));
        send(BC_SPE);
        send(BC_MTA);
        chb(pb[6], 1'b1);
        @(posedge clk_i);
        ps <= 1'b1;
        @(posedge clk_i);
        ps <= 1'b0;
        @(posedge clk_i);
        chb(srq_oe, 1'b0);
        press(2, 30);
        chk({srq, srq_oe}, 2'b01);
        send(BC_MLA);
        chk({bst.talker, bst.listener}, 2'b01);
        send(BC_MTA);
        chk({bst.talker, bst.listener}, 2'b10);
        send(BC_MLA);
        fork send(BC_GET); starts(20, c); join
        chk(c, 1);
        send(BC_DCL);
        chb(srq_oe, 1'b0);
        tap(3'h4);
        send(BC_SDC);
        chb(srq_oe, 1'b0);
        send(BC_REN_ON);
        chb(bst.remote, 1'b1);
        send(BC_GTL);
        chb(bst.remote, 1'b0);
        wb(1'b1, `REG_CTRL, 32'h0000_0002);
        repeat (2) @(posedge clk_i);
        chk({bst.talker, bst.listener}, 2'b10);
        rd(`REG_STATUS, 32'h0000_0010);
    endtask

    // Watchdog: the tests need under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        end_sim;
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_contacts;
        t_alarm;
        t_events;
        t_bus;
        end_sim;
    end
endmodule
`default_nettype wire
